// file: ptmc_map.svh
`ifndef PTMC_MAP_SVH
`define PTMC_MAP_SVH

// Array shape.
`define PTMC_NUM_IN      32
`define PTMC_NUM_FB      9
`define PTMC_NUM_CELLS   16
`define PTMC_NUM_TERMS   32
`define PTMC_VEC_W       41

// Register offsets, byte addresses on the 12-bit APB address.
`define PTMC_TERM_BASE   12'h000
`define PTMC_CELL_BASE   12'h200
`define PTMC_GLOB_ADDR   12'h240
`define PTMC_STAT_ADDR   12'h244

// Words inside one product-term slot of 16 bytes.
`define PTMC_TW_TRUE     2'h0
`define PTMC_TW_COMP     2'h1
`define PTMC_TW_FB       2'h2

// Block-wide control bits.
`define PTMC_G_PTMODE    0
`define PTMC_G_FALL0     1
`define PTMC_G_FALL1     2
`define PTMC_G_INV0      3
`define PTMC_G_INV1      4
`define PTMC_GLOB_W      5
`define PTMC_GLOB_RST    5'h00

// Per-macrocell control bits.
`define PTMC_C_COMB      0
`define PTMC_C_RT_LO     1
`define PTMC_C_RT_HI     2
`define PTMC_C_CLKSEL    3
`define PTMC_C_CLR_LO    4
`define PTMC_C_CLR_HI    5
`define PTMC_C_INV       6
`define PTMC_C_LEND0     7
`define PTMC_C_LEND1     8
`define PTMC_C_CHAIN     9
`define PTMC_C_XOR       10
`define PTMC_CELL_W      11
`define PTMC_CELL_RST    11'h000

// Feedback mask word: true bits low, complement bits from 16 up.
`define PTMC_FB_COMP_LO  16
`define PTMC_FB_W        25

`endif

// file: ptmc_pkg.sv
package ptmc_pkg;

    // Storage behaviour of one macrocell register.
    typedef enum logic [1:0] {
        PTMC_RT_D  = 2'h0,
        PTMC_RT_T  = 2'h1,
        PTMC_RT_JK = 2'h2,
        PTMC_RT_SR = 2'h3
    } ptmc_rtype_t;

    // Clear source selection per macrocell.
    typedef enum logic [1:0] {
        PTMC_CLR_NONE = 2'h0,
        PTMC_CLR_0    = 2'h1,
        PTMC_CLR_1    = 2'h2,
        PTMC_CLR_OFF  = 2'h3
    } ptmc_clrsel_t;

endpackage

// file: ptmc_term.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptmc_map.svh"

// One product term: AND of the literals picked by the two masks.
module ptmc_term (
    // Literal inputs and masks.
    input  wire logic [`PTMC_VEC_W-1:0] vec,
    input  wire logic [`PTMC_VEC_W-1:0] mask_true,
    input  wire logic [`PTMC_VEC_W-1:0] mask_comp,
    // Product result.
    output logic                        term
);

    // An empty term reads as one, so an unprogrammed term is a plain constant.
    assign term = &(~mask_true | vec) & &(~mask_comp | ~vec);

endmodule // ptmc_term
`default_nettype wire

// file: ptmc_cell.sv
`timescale 1ns/100ps
`default_nettype none

// Programmable storage of one macrocell; its flop also drives the output.
module ptmc_cell import ptmc_pkg::*; (
    // System clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Logic inputs.
    input  wire logic        sum,
    input  wire logic        k_in,
    // Control.
    input  wire logic        tick,
    input  wire logic        clr,
    input  wire logic        active,
    input  wire logic        comb,
    input  wire ptmc_rtype_t rtype,
    // Macrocell output.
    output logic            q
);

    // Clear wins over everything; combinatorial use follows the sum each
    // cycle, so it appears one system clock later.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            q <= 1'b0;
        else if (!active || clr)
            q <= 1'b0;
        else if (comb)
            q <= sum;
        else if (tick)
        begin
            case (rtype)
                PTMC_RT_D:  q <= sum;
                PTMC_RT_T:  q <= q ^ sum;
                PTMC_RT_JK: q <= (sum & ~q) | (~k_in & q);
                PTMC_RT_SR: q <= ~k_in & (sum | q);
                default:    q <= q;
            endcase
        end
    end

endmodule // ptmc_cell
`default_nettype wire

// file: ptmc_array.sv
// Operation
// [RULE1] Take 32 logic inputs from local routing.
// [RULE2] Nine macrocell outputs feed back as inputs.
// [RULE3] Product-term mode gives exactly 16 macrocells.
// [RULE4] Each macrocell owns two terms, one register.
// [RULE5] Combinatorial mode bypasses the register.
// [RULE6] Each term goes to sum or lent out.
// [RULE7] One term per macrocell is invertible.
// [RULE8] Register acts as D, T, JK or SR.
// [RULE9] Register uses one of two shared clocks.
// [RULE10] Each shared clock gated by its enable.
// [RULE11] Each shared clock has its own edge.
// [RULE12] Two clears; each cell picks one or none.
// [RULE13] Each clear has its own polarity inversion.
// [RULE14] Up to 32 terms reach one OR.
// [RULE15] Up to 15 borrowed sets chain on.
// [RULE16] PLL outputs never drive data inputs.
// [RULE17] Selected clear forces register to zero.
`timescale 1ns/100ps
`default_nettype none
`include "ptmc_map.svh"

module ptmc_array import ptmc_pkg::*; (
    // System clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    // Local routing inputs; data pins must not carry PLL outputs.
    input  wire logic [31:0] pt_in,
    // Shared clocks, their enables and the two clear sources.
    input  wire logic [1:0]  shclk_src,
    input  wire logic [1:0]  shclk_en,
    input  wire logic [1:0]  aclr_src,
    // Macrocell outputs.
    output logic      [15:0] mc_out
);

    // Configuration storage, one slot per product term and per cell.
    logic [31:0]              term_true_reg [`PTMC_NUM_TERMS];
    logic [31:0]              term_comp_reg [`PTMC_NUM_TERMS];
    logic [`PTMC_FB_W-1:0]    term_fb_reg   [`PTMC_NUM_TERMS];
    logic [`PTMC_CELL_W-1:0]  cell_cfg_reg  [`PTMC_NUM_CELLS];
    logic [`PTMC_GLOB_W-1:0]  glob_reg;

    // Previous level of the shared clocks, for edge detection.
    logic [1:0]               shclk_prev_reg;

    // Datapath signals.
    logic [`PTMC_VEC_W-1:0]   vec;
    logic [`PTMC_NUM_TERMS-1:0] pt_raw;
    logic [15:0]              sum, k_in, exp_in, exp_chain;
    logic [15:0]              tick_cell, clr_cell, comb_cell;
    logic [1:0]               tick, clr_act;
    logic                     chain_prev;
    logic                     ptmode;

    // APB decode.
    logic                     setup_ph, wr_en, term_hit, cell_hit, hit;
    logic [4:0]               t_idx;
    logic [3:0]               c_idx;
    logic [31:0]              rd_data;
    logic                     glob_hit, stat_hit;

    // Region bases as vectors, so that their upper address bits can be sliced.
    localparam logic [11:0]   TERM_BASE = `PTMC_TERM_BASE;
    localparam logic [11:0]   CELL_BASE = `PTMC_CELL_BASE;
    localparam logic [11:0]   GLOB_ADDR = `PTMC_GLOB_ADDR;
    localparam logic [11:0]   STAT_ADDR = `PTMC_STAT_ADDR;

    assign ptmode = glob_reg[`PTMC_G_PTMODE];

    // Outside inputs plus the first nine outputs fed back.
    assign vec = {mc_out[`PTMC_NUM_FB-1:0], pt_in}; // see [RULE1] see [RULE2]

    // Edge pulses on each shared clock, one edge chosen per clock, gated by
    // the paired enable. Both edges in one block therefore take both clocks.
    always_comb
    begin
        tick[0] = (glob_reg[`PTMC_G_FALL0] ? (~shclk_src[0] & shclk_prev_reg[0])
                  : (shclk_src[0] & ~shclk_prev_reg[0])) & shclk_en[0] & ptmode; // see [RULE11]
        tick[1] = (glob_reg[`PTMC_G_FALL1] ? (~shclk_src[1] & shclk_prev_reg[1])
                  : (shclk_src[1] & ~shclk_prev_reg[1])) & shclk_en[1] & ptmode; // see [RULE10]
        clr_act[0] = aclr_src[0] ^ glob_reg[`PTMC_G_INV0]; // see [RULE13]
        clr_act[1] = aclr_src[1] ^ glob_reg[`PTMC_G_INV1]; // see [RULE13]
    end

    // Shared clock history; sampled as synchronous levels.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            shclk_prev_reg <= 2'b00;
        else
            shclk_prev_reg <= shclk_src;
    end

    // The 32 product terms; terms 2m and 2m+1 belong to cell m.
    for (genvar t = 0; t < `PTMC_NUM_TERMS; t++)
    begin : g_term
        ptmc_term u_term (
            .vec       (vec),
            .mask_true ({term_fb_reg[t][8:0], term_true_reg[t]}),
            .mask_comp ({term_fb_reg[t][`PTMC_FB_COMP_LO+8:`PTMC_FB_COMP_LO],
                         term_comp_reg[t]}),
            .term      (pt_raw[t])
        );
    end

    // Select matrix, expander chain and sum logic of all cells. The chain
    // runs upward, so cell 15 can collect the sets of all fifteen below it;
    // each link adds one OR level of delay.
    always_comb
    begin
        chain_prev = 1'b0;
        for (int m = 0; m < `PTMC_NUM_CELLS; m++)
        begin
            logic p0, p1, lend0, lend1, regk;
            p0 = pt_raw[2*m] ^ cell_cfg_reg[m][`PTMC_C_INV]; // see [RULE7]
            p1 = pt_raw[2*m+1];
            lend0 = cell_cfg_reg[m][`PTMC_C_LEND0];
            lend1 = cell_cfg_reg[m][`PTMC_C_LEND1];
            // JK and SR take their second input from the second term.
            regk = ~cell_cfg_reg[m][`PTMC_C_COMB] & cell_cfg_reg[m][`PTMC_C_RT_HI];
            k_in[m] = p1;
            exp_in[m] = cell_cfg_reg[m][`PTMC_C_CHAIN] & chain_prev; // see [RULE15]
            exp_chain[m] = exp_in[m] | (lend0 & p0) | (lend1 & p1); // see [RULE6]
            chain_prev = exp_chain[m];
            sum[m] = ((~lend0 & p0) | (~lend1 & ~regk & p1) | exp_in[m])
                     ^ cell_cfg_reg[m][`PTMC_C_XOR]; // see [RULE4] see [RULE14]
            tick_cell[m] = tick[cell_cfg_reg[m][`PTMC_C_CLKSEL]]; // see [RULE9]
            case (ptmc_clrsel_t'(cell_cfg_reg[m][`PTMC_C_CLR_HI:`PTMC_C_CLR_LO]))
                PTMC_CLR_0: clr_cell[m] = clr_act[0]; // see [RULE12]
                PTMC_CLR_1: clr_cell[m] = clr_act[1]; // see [RULE12]
                default:    clr_cell[m] = 1'b0;
            endcase
            comb_cell[m] = cell_cfg_reg[m][`PTMC_C_COMB];
        end
    end

    // Sixteen macrocells, held cleared while product-term mode is off.
    for (genvar m = 0; m < `PTMC_NUM_CELLS; m++)
    begin : g_cell
        ptmc_cell u_cell (
            .clk_sys (clk_sys),
            .reset_n (reset_n),
            .sum     (sum[m]),
            .k_in    (k_in[m]),
            .tick    (tick_cell[m]),
            .clr     (clr_cell[m]),
            .active  (ptmode),
            .comb    (comb_cell[m]),
            .rtype   (ptmc_rtype_t'(cell_cfg_reg[m][`PTMC_C_RT_HI:`PTMC_C_RT_LO])),
            .q       (mc_out[m])
        ); // see [RULE3] see [RULE5] see [RULE8] see [RULE17]
    end

    // APB address decode; low two address bits are ignored.
    always_comb
    begin
        setup_ph = psel & ~penable;
        t_idx    = paddr[8:4];
        c_idx    = paddr[5:2];
        term_hit = (paddr[11:9] == TERM_BASE[11:9]) && (paddr[3:2] != 2'h3);
        cell_hit = (paddr[11:6] == CELL_BASE[11:6]);
        glob_hit = (paddr[11:2] == GLOB_ADDR[11:2]);
        stat_hit = (paddr[11:2] == STAT_ADDR[11:2]);
        hit      = term_hit | cell_hit | glob_hit | stat_hit;
        wr_en    = psel & penable & pready & pwrite & hit;
        rd_data  = 32'h0000_0000;
        if (term_hit)
        begin
            case (paddr[3:2])
                `PTMC_TW_TRUE: rd_data = term_true_reg[t_idx];
                `PTMC_TW_COMP: rd_data = term_comp_reg[t_idx];
                default:       rd_data = {7'h00, term_fb_reg[t_idx]};
            endcase
        end
        else if (cell_hit)
            rd_data = {21'h00_0000, cell_cfg_reg[c_idx]};
        else if (glob_hit)
            rd_data = {27'h000_0000, glob_reg};
        else if (stat_hit)
            rd_data = {16'h0000, mc_out};
    end

    // Answer in the first access cycle; read data is caught in setup.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit;
            if (setup_ph)
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    // Product-term masks; unused feedback bits are kept but ignored.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int t = 0; t < `PTMC_NUM_TERMS; t++)
            begin
                term_true_reg[t] <= 32'h0000_0000;
                term_comp_reg[t] <= 32'h0000_0000;
                term_fb_reg[t]   <= {`PTMC_FB_W{1'b0}};
            end
        end
        else if (wr_en && term_hit)
        begin
            case (paddr[3:2])
                `PTMC_TW_TRUE: term_true_reg[t_idx] <= pwdata;
                `PTMC_TW_COMP: term_comp_reg[t_idx] <= pwdata;
                default:       term_fb_reg[t_idx]   <= pwdata[`PTMC_FB_W-1:0];
            endcase
        end
    end

    // Per-cell and block-wide control words.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int m = 0; m < `PTMC_NUM_CELLS; m++)
                cell_cfg_reg[m] <= `PTMC_CELL_RST;
            glob_reg <= `PTMC_GLOB_RST;
        end
        else if (wr_en && cell_hit)
            cell_cfg_reg[c_idx] <= pwdata[`PTMC_CELL_W-1:0];
        else if (wr_en && glob_hit)
            glob_reg <= pwdata[`PTMC_GLOB_W-1:0];
    end

    // Checks on the observable behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    property p_mode_off;
        !ptmode |=> (mc_out == 16'h0000);
    endproperty
    a_mode_off: assert property (p_mode_off) // see [RULE3]
        else $error("Macrocell active while product-term mode off.");

    property p_fall_edge;
        glob_reg[`PTMC_G_FALL0] && $fell(shclk_src[0]) && shclk_en[0] && ptmode |-> tick[0];
    endproperty
    a_fall_edge: assert property (p_fall_edge) // see [RULE11]
        else $error("Falling edge of shared clock 0 missed.");

    property p_en_gate;
        !shclk_en[1] |-> !tick[1];
    endproperty
    a_en_gate: assert property (p_en_gate) // see [RULE10]
        else $error("Shared clock 1 ticked with enable low.");

    for (genvar m = 0; m < `PTMC_NUM_CELLS; m++)
    begin : g_chk
        property p_clear;
            clr_cell[m] |=> !mc_out[m];
        endproperty
        a_clear: assert property (p_clear) // see [RULE17]
            else $error("Selected clear did not zero the macrocell.");

        property p_comb;
            ptmode && !clr_cell[m] && comb_cell[m] |=> mc_out[m] == $past(sum[m]);
        endproperty
        a_comb: assert property (p_comb) // see [RULE5]
            else $error("Combinatorial output does not follow the sum.");

        property p_hold;
            ptmode && !clr_cell[m] && !comb_cell[m] && !tick_cell[m] |=> $stable(mc_out[m]);
        endproperty
        a_hold: assert property (p_hold) // see [RULE10]
            else $error("Register changed without a gated clock edge.");

        property p_toggle;
            ptmode && !clr_cell[m] && !comb_cell[m] && tick_cell[m]
            && cell_cfg_reg[m][`PTMC_C_RT_HI:`PTMC_C_RT_LO] == PTMC_RT_T
            |=> mc_out[m] == ($past(mc_out[m]) ^ $past(sum[m]));
        endproperty
        a_toggle: assert property (p_toggle) // see [RULE8]
            else $error("T register did not toggle on its sum.");

        property p_expand;
            exp_in[m] && !cell_cfg_reg[m][`PTMC_C_XOR] |-> sum[m];
        endproperty
        a_expand: assert property (p_expand) // see [RULE14]
            else $error("Borrowed expander did not reach the sum.");

        property p_lend;
            cell_cfg_reg[m][`PTMC_C_LEND0] && cell_cfg_reg[m][`PTMC_C_LEND1] && !exp_in[m]
            |-> sum[m] == cell_cfg_reg[m][`PTMC_C_XOR];
        endproperty
        a_lend: assert property (p_lend) // see [RULE6]
            else $error("Lent term still feeds its own sum.");
    end

    c_both_clocks: cover property (tick[0] && tick[1]);
    c_long_chain:  cover property (exp_in[15] && ptmode);
    c_clear_hit:   cover property (|clr_cell && |mc_out);

endmodule // ptmc_array
`default_nettype wire

// file: ptmc_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none

// Neighbouring logic cells and routing that feed the array.
module ptmc_fabric_model (
    // System clock.
    input  wire logic        clk_sys,
    // Levels toward the array.
    output logic      [31:0] pt_in,
    output logic      [1:0]  shclk_src,
    output logic      [1:0]  shclk_en,
    output logic      [1:0]  aclr_src
);
    // Known levels from time zero; data comes from logic cells only.
    initial
    begin
        pt_in     = 32'h0000_0000;
        shclk_src = 2'h0;
        shclk_en  = 2'h3;
        aclr_src  = 2'h0;
    end

    // The shared clocks are routing levels, so they move on a system edge.
    task automatic drive(input logic [31:0] d, input logic [1:0] c,
                         input logic [1:0] e, input logic [1:0] a);
        @(posedge clk_sys);
        pt_in     <= d;
        shclk_src <= c;
        shclk_en  <= e;
        aclr_src  <= a;
    endtask
endmodule // ptmc_fabric_model

`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptmc_map.svh"

module testbench import ptmc_pkg::*; ;
    // Bus, fabric and bench state.
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, mask, f_pt, seed, pt_in;
    logic [1:0]  shclk_src, shclk_en, aclr_src, f_clk, f_en, f_clr, rtl, sel;
    logic [15:0] mc_out;
    logic        err, a, b, inv, x, en, qe, qn, c, fl, w;
    int          error_cnt, checks_done, i, j, rt, t;

    ptmc_array ptmc_array_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .pt_in(pt_in),
        .shclk_src(shclk_src), .shclk_en(shclk_en), .aclr_src(aclr_src), .mc_out(mc_out));
    ptmc_fabric_model ptmc_fabric_model_i (.clk_sys(clk_sys), .pt_in(pt_in),
        .shclk_src(shclk_src), .shclk_en(shclk_en), .aclr_src(aclr_src));

    // 50 MHz system clock.
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // Prints counts and verdict, then stops.
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen at a rising edge,
    // and read data and pslverr are taken at that same edge.
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR pready expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, ad, d, q, e);
    endtask

    // Register data compare.
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [11:0] ad, input logic [31:0] e, input logic ee);
        apb(1'b0, ad, 32'h0000_0000, rd, err);
        chk_reg("prdata", e, rd);
        chk_reg("pslverr", {31'h0, ee}, {31'h0, err});
    endtask

    // Macrocell output compare, after the fabric pipeline has settled.
    task automatic chk_bit(input int k, input logic e);
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        checks_done++;
        if (mc_out[k] !== e)
        begin
            error_cnt++;
            $display("ERROR mc_out[%0d] expected %b seen %b", k, e, mc_out[k]);
        end
    endtask

    // A term with bit 0 both true and complemented is always 0; no masks gives 1.
    task automatic set_term(input int k, input logic v);
        wr(`PTMC_TERM_BASE + 12'(k * 16), {31'h0, ~v});
        wr(`PTMC_TERM_BASE + 12'(k * 16 + 4), {31'h0, ~v});
    endtask

    task automatic fab();
        ptmc_fabric_model_i.drive(f_pt, f_clk, f_en, f_clr);
    endtask

    // Next register state for D, T, JK and SR with inputs a and b.
    function automatic logic nq(int r, logic q, logic s, logic k);
        case (r)
            0: return s | k;
            1: return q ^ (s | k);
            2: return (s & k) ? ~q : (s ? 1'b1 : (k ? 1'b0 : q));
            default: return k ? 1'b0 : (s ? 1'b1 : q);
        endcase
    endfunction

    // A hang is cut short well inside the cycle budget.
    initial
    begin
        #1_800_000;
        error_cnt++;
        $display("ERROR watchdog expected done seen hang");
        end_sim();
    end

    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {f_pt, f_clk, f_clr} = '0;
        f_en = 2'h3;
        reset_n = 1'b0;
        seed = $urandom(32'h6501);
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Reset values, field widths and an unmapped word.
        chk_reg("mc_out", 32'h0000_0000, {16'h0, mc_out});
        rd_chk(`PTMC_GLOB_ADDR, 32'h0000_0000, 1'b0);
        rd_chk(`PTMC_CELL_BASE + 12'h03C, 32'h0000_0000, 1'b0);
        rd_chk(`PTMC_TERM_BASE + 12'h00C, 32'h0000_0000, 1'b1);
        wr(`PTMC_GLOB_ADDR, 32'hFFFF_FFFF);
        rd_chk(`PTMC_GLOB_ADDR, 32'h0000_001F, 1'b0);
        wr(`PTMC_CELL_BASE + 12'h004, 32'hFFFF_FFFF);
        rd_chk(`PTMC_CELL_BASE + 12'h004, 32'h0000_07FF, 1'b0);
        wr(`PTMC_GLOB_ADDR, 32'h0000_0000);
        for (i = 0; i < 32; i++)
            set_term(i, 1'b0);
        for (i = 0; i < 16; i++)
            wr(`PTMC_CELL_BASE + 12'(i * 4), 32'h0000_0000);
        wr(`PTMC_GLOB_ADDR, 32'h0000_0001);
        $display("test registers done");
        // Random products of all 32 inputs, with term inversion and output XOR.
        // Term 0 drops the complement bit left by set_term, so only its true mask acts.
        wr(`PTMC_TERM_BASE + 12'h004, 32'h0000_0000);
        for (i = 0; i < 8; i++)
        begin
            mask = $urandom & $urandom & $urandom;
            inv = 1'($urandom);
            x = 1'($urandom);
            f_pt = $urandom | (i[0] ? mask : 32'h0000_0000);
            wr(`PTMC_TERM_BASE, mask);
            wr(`PTMC_CELL_BASE, {21'h0, x, 3'h0, inv, 5'h00, 1'b1});
            fab();
            chk_bit(0, (((f_pt & mask) == mask) ^ inv) ^ x);
        end
        wr(`PTMC_TERM_BASE, 32'h0000_0000);
        wr(`PTMC_CELL_BASE, 32'h0000_0001);
        chk_bit(0, 1'b1);
        wr(`PTMC_GLOB_ADDR, 32'h0000_0000);
        chk_bit(0, 1'b0);
        wr(`PTMC_GLOB_ADDR, 32'h0000_0001);
        $display("test combinatorial done");
        // Cell 8 output returns as a literal of term 0.
        wr(`PTMC_CELL_BASE + 12'h020, 32'h0000_0001);
        wr(`PTMC_TERM_BASE + 12'h008, 32'h0000_0100);
        for (i = 1; i >= 0; i--)
        begin
            set_term(16, i[0]);
            chk_bit(0, i[0]);
        end
        wr(`PTMC_TERM_BASE + 12'h008, 32'h0100_0000);
        chk_bit(0, 1'b1);
        wr(`PTMC_TERM_BASE + 12'h008, 32'h0000_0000);
        set_term(0, 1'b0);
        chk_bit(0, 1'b0);
        $display("test feedback done");
        // Fifteen lending cells chained into cell 15.
        for (i = 0; i < 15; i++)
            wr(`PTMC_CELL_BASE + 12'(i * 4), (i == 0) ? 32'h0000_0180 : 32'h0000_0380);
        wr(`PTMC_CELL_BASE + 12'h03C, 32'h0000_0201);
        t = $urandom_range(29, 0);
        set_term(t, 1'b1);
        chk_bit(15, 1'b1);
        rd_chk(`PTMC_STAT_ADDR, 32'h0000_8000, 1'b0);
        set_term(t, 1'b0);
        chk_bit(15, 1'b0);
        wr(`PTMC_CELL_BASE, 32'h0000_0081);
        set_term(0, 1'b1);
        chk_bit(0, 1'b0);
        chk_bit(15, 1'b1);
        set_term(0, 1'b0);
        for (i = 0; i < 16; i++)
            wr(`PTMC_CELL_BASE + 12'(i * 4), 32'h0000_0000);
        $display("test expanders done");
        // Each register type on one clock and edge: D clock 0 rising, T clock 1 rising, JK clock 0 falling, SR clock 1 falling.
        qe = 1'b0;
        for (rt = 0; rt < 4; rt++)
        begin
            rtl = 2'(rt);
            c = rtl[0];
            fl = rtl[1];
            wr(`PTMC_GLOB_ADDR, 32'h0000_0001 | (32'(fl) << (1 + c)));
            wr(`PTMC_CELL_BASE + 12'h004, {28'h0, c, rtl, 1'b0});
            for (j = 0; j < 6; j++)
            begin
                a = 1'($urandom);
                b = 1'($urandom);
                en = (j != 2);
                set_term(2, a);
                set_term(3, b);
                // Only the selected clock's own enable is lowered; the other stays high.
                f_en = en ? 2'h3 : (c ? 2'h1 : 2'h2);
                f_clk[c] = 1'b1;
                fab();
                qn = (en && !fl) ? nq(rt, qe, a, b) : qe;
                chk_bit(1, qn);
                qe = qn;
                f_clk[c] = 1'b0;
                fab();
                qn = (en && fl) ? nq(rt, qe, a, b) : qe;
                chk_bit(1, qn);
                qe = qn;
            end
        end
        f_en = 2'h3;
        $display("test register types done");
        // Each clear selection against each clear, both polarities.
        set_term(2, 1'b1);
        for (i = 0; i < 16; i++)
        begin
            sel = 2'(i / 4);
            inv = i[1];
            w = i[0];
            f_clr = {inv, inv};
            fab();
            wr(`PTMC_GLOB_ADDR, {27'h0, inv, inv, 2'h0, 1'b1});
            wr(`PTMC_CELL_BASE + 12'h004, {26'h0, sel, 4'h0});
            f_clk[0] = 1'b1;
            fab();
            chk_bit(1, 1'b1);
            f_clk[0] = 1'b0;
            f_clr[w] = ~inv;
            fab();
            qn = !((sel == 2'h1 && !w) || (sel == 2'h2 && w));
            chk_bit(1, qn);
            f_clk[0] = 1'b1;
            fab();
            chk_bit(1, qn);
            f_clk[0] = 1'b0;
            fab();
        end
        $display("test clears done");
        end_sim();
    end
endmodule // testbench

`default_nettype wire
